// ---- rtl/sxc_consts.vh ----
// register map, field positions and timing constants for the transfer control block
`ifndef SXC_CONSTS_VH
`define SXC_CONSTS_VH
// register offsets
`define SXC_SEQ_CTL      8'h00
`define SXC_XFER_CTL_A   8'h01
`define SXC_XFER_CTL_B   8'h02
`define SXC_BUS_SIG      8'h03
`define SXC_LATCH_LO     8'h06
`define SXC_CNT_B0       8'h08
`define SXC_CNT_B1       8'h09
`define SXC_CNT_B2       8'h0a
`define SXC_CLR_ZERO     8'h0b
`define SXC_STAT_ONE     8'h0c
`define SXC_SEL_TIMER    8'h0d
// transfer_control_a fields
`define SXC_A_CLR_CNT    4
`define SXC_A_PIO_EN     3
`define SXC_A_CLR_CHN    1
// transfer_control_b fields
`define SXC_B_DISCARD    7
`define SXC_B_WRAP_EN    6
`define SXC_B_PAR_EN     5
`define SXC_B_TSEL_HI    4
`define SXC_B_TSEL_LO    3
`define SXC_B_TMR_EN     2
// sequence control, status_one and clear fields
`define SXC_SEQ_AUTO_ATN 1
`define SXC_S1_TMOUT     7
`define SXC_S1_PERR      2
`define SXC_C1_CLR_ATN   6
`define SXC_C1_CLR_TMOUT 7
`define SXC_C1_CLR_PERR  2
`define SXC_C0_CLR_WRAP  3
// bus signal bit positions
`define SXC_SIG_CD       7
`define SXC_SIG_IO       6
`define SXC_SIG_MSG      5
`define SXC_SIG_ATN      4
`define SXC_SIG_SEL      3
`define SXC_SIG_BSY      2
`define SXC_SIG_REQ      1
`define SXC_SIG_ACK      0
// timing: longest timeout, clock rate, timer steps
`define SXC_TIMEOUT_MS   256
`define SXC_CLK_KHZ      40000
`define SXC_TMR_STEPS    64
`define SXC_TICK_CYC     ((`SXC_TIMEOUT_MS * `SXC_CLK_KHZ) / `SXC_TMR_STEPS)
// reset values and the all-ones count loaded on a wrap
`define SXC_ZERO8        8'h00
`define SXC_ZERO24       24'h00_0000
`define SXC_ONES24       24'hff_ffff
`endif

// ---- rtl/sxc_ctrl.v ----
// transfer control, bus signal sense/drive and selection timer block
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "sxc_consts.vh"

module sxc_ctrl #(
  parameter TICK_CYC = `SXC_TICK_CYC  // cycles per timer step at 256 ms
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // register port
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  // mode and path controls from the data path
  input  wire        target_mode,
  input  wire        bus_transfer_enable,
  input  wire        bus_dma_enable,
  input  wire        xfer_byte,
  input  wire        host_byte,
  // bus control pins, logical level, 1 = asserted
  input  wire [7:0]  sig_in,
  output wire [7:0]  sig_out,
  output wire [7:0]  sig_oe,
  input  wire        bus_rst_in,
  // bus data pins
  input  wire [7:0]  data_in,
  input  wire        par_in,
  output reg  [7:0]  data_out,
  output wire        data_oe,
  // status and strobes to the data path
  output wire        chan_clear,
  output wire        transfer_done,
  output wire [23:0] transfer_count,
  output wire [23:0] host_address
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // odd parity across data and parity bit
  function par_bad;
    input [7:0] d;
    input       p;
    begin
      par_bad = ~(^{d, p});
    end
  endfunction

  // register address hit, for writes and reads
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [7:0]  sig_m_q;      // synchroniser first stage
  reg  [7:0]  sig_s_q;      // synchronised pin levels
  reg  [7:0]  sig_p_q;      // previous synchronised levels
  reg  [1:0]  rst_s_q;      // bus reset synchroniser
  reg         pio_en_q;     // auto PIO enable
  reg  [5:0]  ctl_b_q;      // transfer_control_b bits 7..2
  reg         auto_atn_q;   // auto attention on parity
  reg  [7:0]  drive_q;      // bus_signal_drive
  reg  [23:0] cnt_q;        // transfer_count
  reg  [23:0] hadr_q;       // host_address_counter
  reg         wrapped_q;    // count_wrapped flag
  reg         perr_q;       // parity_error_flag
  reg         tmout_q;      // selection_timed_out
  reg  [7:0]  latch_q;      // latched_data_low
  reg         hs_q;         // PIO handshake strobe asserted
  reg  [1:0]  pio_st_q;     // PIO state
  reg  [5:0]  tmr_q;        // selection_timer_value
  reg  [17:0] pre_q;        // timer prescaler
  reg         clr_chn_q;    // clear channel pulse
  // pio states
  localparam [1:0] PIO_IDLE = 2'd0;
  localparam [1:0] PIO_HS   = 2'd1;
  localparam [1:0] PIO_WAIT = 2'd2;
  wire initiator = ~target_mode;
  wire wr_a  = wr & hit(addr, `SXC_XFER_CTL_A);
  wire wr_b  = wr & hit(addr, `SXC_XFER_CTL_B);
  wire wr_s  = wr & hit(addr, `SXC_BUS_SIG);
  wire wr_c0 = wr & hit(addr, `SXC_CLR_ZERO);
  wire wr_c1 = wr & hit(addr, `SXC_STAT_ONE);
  wire lat_acc = (wr | rd) & hit(addr, `SXC_LATCH_LO);
  wire clr_cnt = wr_a & wdata[`SXC_A_CLR_CNT];
  wire clr_chn = wr_a & wdata[`SXC_A_CLR_CHN];
  wire discard  = ctl_b_q[`SXC_B_DISCARD - 2];
  wire wrap_en  = ctl_b_q[`SXC_B_WRAP_EN - 2];
  wire par_en   = ctl_b_q[`SXC_B_PAR_EN - 2];
  wire [1:0] tsel = ctl_b_q[`SXC_B_TSEL_HI - 2:`SXC_B_TSEL_LO - 2];
  wire tmr_en   = ctl_b_q[`SXC_B_TMR_EN - 2];
  wire pio_live = pio_en_q & ~bus_transfer_enable & ~bus_dma_enable;
  wire bucket = discard & initiator;
  // peer strobe: REQ seen by initiator, ACK by target
  wire peer_s = initiator ? sig_s_q[`SXC_SIG_REQ] : sig_s_q[`SXC_SIG_ACK];
  wire peer_p = initiator ? sig_p_q[`SXC_SIG_REQ] : sig_p_q[`SXC_SIG_ACK];
  wire peer_rise = peer_s & ~peer_p;
  wire inbound = sig_s_q[`SXC_SIG_IO] ^ target_mode;
  // bus free: BSY and SEL both drop
  wire busy_p   = sig_p_q[`SXC_SIG_BSY] | sig_p_q[`SXC_SIG_SEL];
  wire busy_s   = sig_s_q[`SXC_SIG_BSY] | sig_s_q[`SXC_SIG_SEL];
  wire bus_free = busy_p & ~busy_s;
  wire bus_rst  = rst_s_q[1];
  // outbound selection: own SEL out, no BSY reply yet
  wire sel_out = drive_q[`SXC_SIG_SEL] & ~sig_s_q[`SXC_SIG_BSY];
  // prescale count for the chosen timeout
  wire [17:0] tick_max = TICK_CYC[17:0] >> tsel;
  wire tick = (pre_q >= tick_max - 18'd1);
  wire expire = tmr_en & sel_out & tick & (tmr_q == 6'h3f);
  // parity check moment: selection phases or inbound info
  wire sel_phase = sig_s_q[`SXC_SIG_SEL];
  wire chk = par_en & (peer_rise & inbound | sel_phase & ~sig_p_q[`SXC_SIG_SEL]);
  wire perr_ev = chk & par_bad(data_in, par_in);
  // auto attention: initiator, inbound phases only
  wire atn_ev = perr_ev & auto_atn_q & initiator & sig_s_q[`SXC_SIG_IO];

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  // first stage feeds only the second stage
  // two-stage pin synchroniser
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sig_m_q <= `SXC_ZERO8;
      sig_s_q <= `SXC_ZERO8;
      sig_p_q <= `SXC_ZERO8;
      rst_s_q <= 2'b00;
    end else begin
      sig_m_q <= sig_in;
      sig_s_q <= sig_m_q;
      sig_p_q <= sig_s_q;
      rst_s_q <= {rst_s_q[0], bus_rst_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  // control bits written by software
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pio_en_q   <= 1'b0;
      ctl_b_q    <= 6'h00;
      auto_atn_q <= 1'b0;
      clr_chn_q  <= 1'b0;
    end else begin
      clr_chn_q <= clr_chn;
      // clearing enable only stops new handshakes
      if (wr_a)
        pio_en_q <= wdata[`SXC_A_PIO_EN];
      if (wr_b)
        ctl_b_q <= wdata[7:2];
      if (wr & hit(addr, `SXC_SEQ_CTL))
        auto_atn_q <= wdata[`SXC_SEQ_AUTO_ATN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters

  // transfer and host address counters
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= `SXC_ZERO24;
      hadr_q    <= `SXC_ZERO24;
      wrapped_q <= 1'b0;
    end else begin
      if (clr_cnt) begin
        cnt_q  <= `SXC_ZERO24;
        hadr_q <= `SXC_ZERO24;
      end else begin
        if (host_byte)
          hadr_q <= hadr_q + 24'h00_0001;
        if (xfer_byte) begin
          if (cnt_q != `SXC_ZERO24)
            cnt_q <= cnt_q - 24'h00_0001;
          else if (wrap_en)
            cnt_q <= `SXC_ONES24;
        end
      end
      // software clears; a new wrap wins
      if (xfer_byte & ~clr_cnt & wrap_en & (cnt_q == `SXC_ZERO24))
        wrapped_q <= 1'b1;
      else if (wr_c0 & wdata[`SXC_C0_CLR_WRAP])
        wrapped_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // automatic PIO handshake
  // one byte per latch access, finished by the peer strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pio_st_q <= PIO_IDLE;
      hs_q     <= 1'b0;
      latch_q  <= `SXC_ZERO8;
    end else begin
      // a latch write or inbound bus data loads the latch, except while discarding
      if (wr & hit(addr, `SXC_LATCH_LO) & ~bucket)
        latch_q <= wdata;
      if (peer_rise & inbound & ~bucket)
        latch_q <= data_in;
      if (clr_chn) begin
        pio_st_q <= PIO_IDLE;
        hs_q     <= 1'b0;
      end else begin
        case (pio_st_q)
          PIO_IDLE: begin
            if (pio_live & lat_acc) begin
              hs_q     <= 1'b1;
              pio_st_q <= PIO_HS;
            end
          end
          PIO_HS: begin
            // initiator waits REQ low, target waits ACK high
            if (initiator ? ~peer_s : peer_s) begin
              hs_q     <= 1'b0;
              pio_st_q <= initiator ? PIO_IDLE : PIO_WAIT;
            end
          end
          PIO_WAIT: begin
            // target waits for ACK to drop
            if (~peer_s)
              pio_st_q <= PIO_IDLE;
          end
          default: begin
            pio_st_q <= PIO_IDLE;
            hs_q     <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // selection timer

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 18'h0_0000;
      tmr_q <= 6'h00;
    end else if (~sel_out | ~tmr_en) begin
      // idle between selections
      pre_q <= 18'h0_0000;
      tmr_q <= 6'h00;
    end else if (tick) begin
      pre_q <= 18'h0_0000;
      tmr_q <= tmr_q + 6'h01;
    end else begin
      pre_q <= pre_q + 18'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags, set wins over clear

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      perr_q  <= 1'b0;
      tmout_q <= 1'b0;
    end else begin
      if (perr_ev)
        perr_q <= 1'b1;
      else if (wr_c1 & wdata[`SXC_C1_CLR_PERR])
        perr_q <= 1'b0;
      if (expire)
        tmout_q <= 1'b1;
      else if (wr_c1 & wdata[`SXC_C1_CLR_TMOUT])
        tmout_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus signal drive register

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_q <= `SXC_ZERO8;
    end else if (bus_rst | bus_free) begin
      // bus reset or bus free clears all
      drive_q <= `SXC_ZERO8;
    end else begin
      if (wr_s) begin
        // phase bits, SEL BSY REQ ACK stored
        drive_q[7:5] <= wdata[7:5];
        drive_q[3:0] <= wdata[3:0];
      end
      // attention set only by a one written as initiator, or by auto attention on parity
      if ((wr_s & wdata[`SXC_SIG_ATN] & initiator) | atn_ev)
        drive_q[`SXC_SIG_ATN] <= 1'b1;
      else if (wr_c1 & wdata[`SXC_C1_CLR_ATN])
        drive_q[`SXC_SIG_ATN] <= 1'b0;
      if (expire)
        drive_q[`SXC_SIG_SEL] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive

  // SEL and BSY in either role
  // REQ target only, ACK initiator only
  assign sig_oe = {{3{target_mode}}, initiator, 2'b11, target_mode, initiator};
  assign sig_out = {drive_q[7:2],
                    drive_q[`SXC_SIG_REQ] | (hs_q & target_mode),
                    drive_q[`SXC_SIG_ACK] | (hs_q & initiator)} & sig_oe;

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      data_out <= `SXC_ZERO8;
    else
      data_out <= bucket ? `SXC_ZERO8 : latch_q;
  end
  assign data_oe = ~inbound & busy_s;
  assign chan_clear     = clr_chn_q;
  assign transfer_done  = (cnt_q == `SXC_ZERO24) & ~wrap_en & bus_dma_enable;
  assign transfer_count = cnt_q;
  assign host_address   = hadr_q;
  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `SXC_ZERO8;
    end else if (rd) begin
      case (addr)
        // unused and self-clearing bits read zero
        `SXC_XFER_CTL_A: rdata <= {4'h0, pio_en_q, 3'b000};
        `SXC_XFER_CTL_B: rdata <= {ctl_b_q, 2'b00};
        `SXC_BUS_SIG:    rdata <= sig_s_q;
        `SXC_SEQ_CTL:    rdata <= {6'h00, auto_atn_q, 1'b0};
        `SXC_LATCH_LO:   rdata <= latch_q;
        `SXC_CNT_B0:     rdata <= cnt_q[7:0];
        `SXC_CNT_B1:     rdata <= cnt_q[15:8];
        `SXC_CNT_B2:     rdata <= cnt_q[23:16];
        `SXC_CLR_ZERO:   rdata <= {4'h0, wrapped_q, 3'b000};
        // parity flag masked while checking off
        `SXC_STAT_ONE:   rdata <= {tmout_q, 4'h0, perr_q & par_en, 2'b00};
        `SXC_SEL_TIMER:  rdata <= {2'b00, tmr_q};
        default:         rdata <= `SXC_ZERO8;
      endcase
    end else begin
      rdata <= `SXC_ZERO8;
    end
  end

endmodule // sxc_ctrl

// ---- verification/sxc_ctrl_monitor.sv ----
// assertion checker for the transfer control block ports
`timescale 1ns/1ps
module sxc_ctrl_monitor (
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // register port
  input wire [7:0]  addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  rdata,
  // bus side
  input wire        target_mode,
  input wire        xfer_byte,
  input wire        host_byte,
  input wire [7:0]  sig_in,
  input wire [7:0]  sig_out,
  input wire [7:0]  sig_oe,
  input wire        bus_rst_in,
  // data path status
  input wire        chan_clear,
  input wire [23:0] transfer_count,
  input wire [23:0] host_address
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // clear channel write, counters left alone
  sequence s_chn_wr;
    wr && addr == 8'h01 && wdata[1];
  endsequence
  sequence s_chn_only;
    s_chn_wr ##0 (!wdata[4] && !xfer_byte && !host_byte);
  endsequence
  property p_oe_role;
    sig_oe == {{3{target_mode}}, !target_mode, 2'b11, target_mode, !target_mode};
  endproperty
  property p_masked;
    (sig_out & ~sig_oe) == 8'h00;
  endproperty
  property p_ctla_zero;
    rd && addr == 8'h01 |=> (rdata & 8'hf7) == 8'h00;
  endproperty
  property p_clr_cnt;
    wr && addr == 8'h01 && wdata[4] |=> transfer_count == 24'h00_0000 && host_address == 24'h00_0000;
  endproperty
  property p_chan_pulse;
    s_chn_wr |=> chan_clear ##1 !chan_clear;
  endproperty
  property p_chan_keep;
    s_chn_only |=> $stable(transfer_count) && $stable(host_address);
  endproperty
  property p_bus_rst;
    bus_rst_in [*5] |-> sig_out == 8'h00;
  endproperty
  property p_sense;
    ($stable(sig_in)) [*4] ##0 (rd && addr == 8'h03) |=> rdata == $past(sig_in);
  endproperty
  property p_atn_hold;
    !target_mode && sig_out[4] && !bus_rst_in && wr && addr == 8'h03 && !wdata[4] |=> sig_out[4];
  endproperty
  a_oe_role: assert property (p_oe_role) else $error("role enables wrong");
  a_masked: assert property (p_masked) else $error("undriven bit shown");
  a_ctla_zero: assert property (p_ctla_zero) else $error("ctl a spare bit set");
  a_clr_cnt: assert property (p_clr_cnt) else $error("counters not cleared");
  a_chan_pulse: assert property (p_chan_pulse) else $error("clear pulse wrong");
  a_chan_keep: assert property (p_chan_keep) else $error("counters changed");
  a_bus_rst: assert property (p_bus_rst) else $error("drive kept in bus reset");
  a_sense: assert property (p_sense) else $error("sense value wrong");
  a_atn_hold: assert property (p_atn_hold) else $error("attention dropped");
endmodule // sxc_ctrl_monitor

// ---- verification/sxc_peer.sv ----
// far side bus peer: answers REQ with ACK, or raises REQ itself
`timescale 1ns/1ps
module sxc_peer (
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // scenario controls
  input wire        go,
  input wire [2:0]  phase,
  input wire [7:0]  byte_v,
  input wire        bad_par,
  input wire        slow,
  // bus
  input wire        target_mode,
  input wire [7:0]  dut_sig,
  output wire [7:0] sig_in,
  output wire [7:0] data_in,
  output wire       par_in
);
  reg       req_q;   // peer REQ, block is initiator
  reg       ack_q;   // peer ACK, block is target
  reg [3:0] wait_q;  // answer delay count
  reg [7:0] last_q;  // last byte put out
  // wired-or control lines
  assign sig_in = dut_sig | {req_q ? phase : 3'b000, 3'b000, req_q, ack_q};
  // released data shows inverse of last byte, never a stale copy
  assign data_in = req_q ? byte_v : ~last_q;
  // odd parity, spoiled on request
  assign par_in = ~^data_in ^ bad_par;
  ////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_q <= 1'b0;
      ack_q <= 1'b0;
      wait_q <= 4'h0;
      last_q <= 8'h00;
    end else if (target_mode) begin
      req_q <= 1'b0;
      if (dut_sig[1] && !ack_q) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= {slow, 3'b000})
          ack_q <= 1'b1;
      end else if (!dut_sig[1]) begin
        ack_q <= 1'b0;
        wait_q <= 4'h0;
      end
    end else begin
      ack_q <= 1'b0;
      if (go && !req_q && !dut_sig[0])
        req_q <= 1'b1;
      else if (dut_sig[0] || !go)
        req_q <= 1'b0;
      if (req_q)
        last_q <= byte_v;
    end
  end
endmodule // sxc_peer

// ---- verification/testbench.sv ----
// self-checking bench for the transfer control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  reg clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [7:0] addr = 8'h00, wdata = 8'h00, byte_v = 8'h00;
  reg target_mode = 1'b0, xen = 1'b0, dma = 1'b0, xb = 1'b0, hb = 1'b0;
  reg bus_rst = 1'b0, go = 1'b0, bad_par = 1'b0, slow = 1'b0;
  reg [2:0] phase = 3'b000;
  wire [7:0] rdata, sig_in, sig_out, sig_oe, data_in, data_out;
  wire [23:0] transfer_count, host_address;
  wire par_in, transfer_done, data_oe;
  wire [7:0] dut_sig = sig_out & sig_oe;
  int n_mismatch = 0, check_count = 0, n;
  always #12.5 clk = ~clk;
  sxc_ctrl #(.TICK_CYC(16)) i_sxc_ctrl (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .target_mode(target_mode), .bus_transfer_enable(xen),
    .bus_dma_enable(dma), .xfer_byte(xb), .host_byte(hb), .sig_in(sig_in), .sig_out(sig_out),
    .sig_oe(sig_oe), .bus_rst_in(bus_rst), .data_in(data_in), .par_in(par_in),
    .data_out(data_out), .data_oe(data_oe), .chan_clear(), .transfer_done(transfer_done),
    .transfer_count(transfer_count), .host_address(host_address));
  sxc_peer i_sxc_peer (.clk(clk), .rstn(rstn), .go(go), .phase(phase), .byte_v(byte_v),
    .bad_par(bad_par), .slow(slow), .target_mode(target_mode), .dut_sig(dut_sig),
    .sig_in(sig_in), .data_in(data_in), .par_in(par_in));
  ////////////////////////////////////////////////////////////////
  // settled look after the next edge
  task tick;
    begin @(posedge clk); #1; end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1; @(posedge clk); wr <= 1'b0; end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    begin @(posedge clk); addr <= a; rd <= 1'b1; @(posedge clk); rd <= 1'b0; #1 d = rdata; end
  endtask
  task t_regs;
    reg [7:0] d;
    begin
      rd_reg(8'h01, d); `CHK("ctl_a reset", 8'h00, d)
      rd_reg(8'h02, d); `CHK("ctl_b reset", 8'h00, d)
      wr_reg(8'h01, 8'hff); rd_reg(8'h01, d); `CHK("ctl_a bits", 8'h08, d)
      wr_reg(8'h02, 8'hff); rd_reg(8'h02, d); `CHK("ctl_b bits", 8'hfc, d)
      rd_reg(8'h3f, d); `CHK("unmapped", 8'h00, d)
      wr_reg(8'h02, 8'h00);
      $display("test regs done");
    end
  endtask
  task t_count;
    reg [7:0] d;
    begin
      // count bytes have no write path here, so a wrap from zero makes a nonzero count
      wr_reg(8'h02, 8'h40);
      @(posedge clk) begin hb <= 1'b1; xb <= 1'b1; end
      @(posedge clk) begin hb <= 1'b0; xb <= 1'b0; end
      tick; `CHK("wrapped", 24'hff_ffff, transfer_count)
      rd_reg(8'h0b, d); `CHK("wrap flag", 1'b1, d[3])
      wr_reg(8'h01, 8'h02); tick;
      `CHK("count kept", 24'hff_ffff, transfer_count)
      `CHK("addr kept", 24'h00_0001, host_address)
      wr_reg(8'h0b, 8'h08); rd_reg(8'h0b, d); `CHK("wrap clr", 1'b0, d[3])
      wr_reg(8'h01, 8'h10); tick;
      `CHK("count clr", 24'h00_0000, transfer_count)
      `CHK("addr clr", 24'h00_0000, host_address)
      wr_reg(8'h02, 8'h00); `CHK("not done", 1'b0, transfer_done)
      @(posedge clk) dma <= 1'b1; tick;
      `CHK("done", 1'b1, transfer_done)
      @(posedge clk) dma <= 1'b0;
      $display("test count done");
    end
  endtask
  task t_drive;
    reg [7:0] d;
    begin
      @(posedge clk) target_mode <= 1'b1;
      wr_reg(8'h03, 8'he4); tick; `CHK("tgt drive", 8'he4, sig_out)
      repeat (4) tick; `CHK("oe out", 1'b1, data_oe)
      rd_reg(8'h03, d); `CHK("sense", 8'he4, d)
      wr_reg(8'h03, 8'h14); tick; `CHK("tgt atn", 8'h04, sig_out)
      @(posedge clk) target_mode <= 1'b0;
      tick; `CHK("tgt atn off", 8'h04, sig_out)
      wr_reg(8'h03, 8'hff); tick; `CHK("ini drive", 8'h1d, sig_out)
      wr_reg(8'h03, 8'h04); tick; `CHK("atn kept", 8'h14, sig_out)
      wr_reg(8'h0c, 8'h40); tick; `CHK("atn clr", 8'h04, sig_out)
      wr_reg(8'h03, 8'h14); wr_reg(8'h03, 8'h00);
      repeat (6) tick; `CHK("bus free", 8'h00, sig_out)
      wr_reg(8'h03, 8'h1c); @(posedge clk) bus_rst <= 1'b1;
      repeat (6) tick; `CHK("bus reset", 8'h00, sig_out)
      @(posedge clk) bus_rst <= 1'b0; repeat (4) tick;
      $display("test drive done");
    end
  endtask
  task t_pio;
    begin
      @(posedge clk) target_mode <= 1'b1; slow <= 1'b1;
      wr_reg(8'h03, 8'h44); wr_reg(8'h01, 8'h08); wr_reg(8'h06, 8'ha5); tick;
      `CHK("req up", 1'b1, sig_out[1])
      repeat (5) tick; `CHK("req stands", 1'b1, sig_out[1])
      `CHK("pio data", 8'ha5, data_out)
      n = 0; while (sig_out[1] === 1'b1 && n < 40) begin tick; n++; end
      `CHK("req down", 1'b0, sig_out[1])
      repeat (8) tick; @(posedge clk) xen <= 1'b1;
      wr_reg(8'h06, 8'h5a); repeat (3) tick; `CHK("xfer wins", 1'b0, sig_out[1])
      @(posedge clk) xen <= 1'b0;
      wr_reg(8'h01, 8'h00); wr_reg(8'h06, 8'h5a); repeat (3) tick;
      `CHK("pio off", 1'b0, sig_out[1])
      @(posedge clk) target_mode <= 1'b0;
      wr_reg(8'h02, 8'h80); wr_reg(8'h06, 8'h77); tick; `CHK("discard", 8'h00, data_out)
      wr_reg(8'h02, 8'h00); wr_reg(8'h03, 8'h00); repeat (6) tick;
      $display("test pio done");
    end
  endtask
  task t_parity;
    reg [7:0] d;
    begin
      wr_reg(8'h03, 8'h04); wr_reg(8'h00, 8'h02); wr_reg(8'h02, 8'h20);
      @(posedge clk) phase <= 3'b010; byte_v <= 8'h3c; bad_par <= 1'b1; go <= 1'b1;
      repeat (6) tick; `CHK("oe in", 1'b0, data_oe)
      // initiator PIO: latch read answers the held REQ with ACK
      wr_reg(8'h01, 8'h08); rd_reg(8'h06, d); `CHK("ini latch", 8'h3c, d)
      `CHK("ack up", 1'b1, sig_out[0])
      @(posedge clk) go <= 1'b0;
      repeat (4) tick; `CHK("ack down", 1'b0, sig_out[0])
      wr_reg(8'h01, 8'h00);
      rd_reg(8'h0c, d); `CHK("par flag", 1'b1, d[2])
      `CHK("auto atn", 1'b1, sig_out[4])
      wr_reg(8'h02, 8'h00); rd_reg(8'h0c, d); `CHK("par masked", 1'b0, d[2])
      @(posedge clk) bad_par <= 1'b0;
      wr_reg(8'h0c, 8'h44); wr_reg(8'h03, 8'h00); repeat (6) tick;
      $display("test parity done");
    end
  endtask
  task t_timer;
    reg [7:0] d;
    int e;
    begin
      for (int c = 0; c < 4; c++) begin
        e = 64 * (16 >> c);
        wr_reg(8'h02, {3'b000, c[1:0], 3'b100}); wr_reg(8'h03, 8'h08);
        // step off the write edge so SEL is seen settled
        #1 n = 0;
        while (sig_out[3] === 1'b1 && n < 2000) begin tick; n++; end
        // prescaler phase leaves a few cycles of slack
        `CHK("timeout len", 1'b1, (n > e - 6 && n < e + 6))
        rd_reg(8'h0c, d); `CHK("timed out", 1'b1, d[7])
        wr_reg(8'h0c, 8'h80); repeat (6) tick;
      end
      wr_reg(8'h02, 8'h00); wr_reg(8'h03, 8'h08); repeat (1100) tick;
      `CHK("sel kept", 1'b1, sig_out[3])
      wr_reg(8'h03, 8'h00);
      $display("test timer done");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs; t_count; t_drive; t_pio; t_parity; t_timer;
    wrap_up;
  end
endmodule // testbench
bind sxc_ctrl sxc_ctrl_monitor u_mon (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .target_mode(target_mode), .xfer_byte(xfer_byte),
  .host_byte(host_byte), .sig_in(sig_in), .sig_out(sig_out), .sig_oe(sig_oe),
  .bus_rst_in(bus_rst_in), .chan_clear(chan_clear), .transfer_count(transfer_count),
  .host_address(host_address));
